// file: common/rmc_pkg.sv
// package: mode enum, timing constants and grouped carriers for the radio mode control
package rmc_pkg;

	// ----------------------------------------
	// clock and timing
	// ----------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int STBY2ACT_US = 130;
	localparam int STBY2ACT_CYC = STBY2ACT_US * CLK_MHZ;
	localparam int CE_MIN_US = 10;
	localparam int CE_MIN_CYC = CE_MIN_US * CLK_MHZ;
	localparam int CS_HOLD_US = 128;
	localparam int CS_HOLD_CYC = CS_HOLD_US * CLK_MHZ;
	localparam int PD2STBY_XO_US = 1500;
	localparam int PD2STBY_EXT_US = 150;
	localparam int BASE_FREQ_MHZ = 2400;
	localparam int CNT_W = 16;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [6:0] CH_RST = 7'h02;
	localparam logic [1:0] PWR_RST = 2'h3;

	// ----------------------------------------
	// output power codes
	// ----------------------------------------
	localparam logic [1:0] PWR_0DBM = 2'h3;
	localparam logic [1:0] PWR_M6DBM = 2'h2;
	localparam logic [1:0] PWR_M12DBM = 2'h1;
	localparam logic [1:0] PWR_M18DBM = 2'h0;

	typedef enum logic [2:0] {
		ST_POR,
		ST_PDOWN,
		ST_STBY1,
		ST_STBY2,
		ST_SETTLE,
		ST_RX,
		ST_TX
	} rmc_mode_e;

	// radio setup word carried to the analog side
	typedef struct packed {
		logic air_rate_select;
		logic [1:0] output_power_level;
		logic low_noise_gain_bit;
		logic [6:0] channel_number;
	} rmc_radio_s;

	// ----------------------------------------
	// receive packet outcome
	// ----------------------------------------
	typedef struct packed {
		logic valid;
		logic addr_match;
		logic crc_ok;
	} rmc_rxpkt_s;

endpackage : rmc_pkg

// file: rtl/rmc_sync.sv
// file: two flip-flop synchroniser for one level
`timescale 1ns/1ps
module rmc_sync
(
	input wire logic core_clk_i,
	input wire logic srst_i,
	input wire logic async_i,
	output logic sync_o
);
	logic meta_q;
	logic sync_q;

	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end
		else
		begin
			meta_q <= async_i;
			sync_q <= meta_q;
		end
	end

	assign sync_o = sync_q;
endmodule : rmc_sync

// file: rtl/rmc_hold_timer.sv
// file: counter that reports when a level has stood for a set number of cycles
`timescale 1ns/1ps
module rmc_hold_timer
(
	input wire logic core_clk_i,
	input wire logic srst_i,
	input wire logic level_i,
	input wire logic [rmc_pkg::CNT_W-1:0] limit_i,
	output logic done_o
);
	logic [rmc_pkg::CNT_W-1:0] cnt_q;

	always_ff @(posedge core_clk_i)
	begin
		if (srst_i || !level_i)
			cnt_q <= '0;
		else if (cnt_q < limit_i)
			cnt_q <= cnt_q + 16'h0001;
	end

	assign done_o = level_i && (cnt_q >= limit_i);
endmodule : rmc_hold_timer

// file: rtl/rmc_mode_ctrl.sv
// file: operating mode state machine of the packet radio
`timescale 1ns/1ps
module rmc_mode_ctrl
(
	input wire logic core_clk_i,
	input wire logic srst_i,
	input wire logic power_on_bit_i,
	input wire logic listen_role_bit_i,
	input wire logic air_rate_select_i,
	input wire logic [6:0] channel_number_i,
	input wire logic [1:0] output_power_level_i,
	input wire logic low_noise_gain_bit_i,
	input wire logic activate_pin_i,
	input wire logic select_n_pin_i,
	input wire logic tx_fifo_empty_i,
	input wire logic packet_done_i,
	input wire logic rx_signal_i,
	input wire rmc_pkg::rmc_rxpkt_s rx_pkt_i,
	input wire logic rx_fifo_full_i,
	output rmc_pkg::rmc_mode_e mode_o,
	output logic carrier_sense_o,
	output logic rx_store_o,
	output logic rx_drop_o,
	output logic tx_pop_o,
	output rmc_pkg::rmc_radio_s radio_o,
	output logic [11:0] freq_mhz_o
);
	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic act_s;
	logic sel_n_s;
	logic rx_sig_s;
	logic [2:0] pin_raw;
	logic [2:0] pin_s;
	assign pin_raw = {rx_signal_i, select_n_pin_i, activate_pin_i};
	for (genvar g = 0; g < 3; g++)
	begin : g_sync
		rmc_sync u_sync
		(
			.core_clk_i(core_clk_i),
			.srst_i(srst_i),
			.async_i(pin_raw[g]),
			.sync_o(pin_s[g])
		);
	end
	assign act_s = pin_s[0];
	assign sel_n_s = pin_s[1];
	assign rx_sig_s = pin_s[2];

	// ----------------------------------------
	// activate pulse width and select edge
	// ----------------------------------------
	logic ce_long;
	logic sel_n_d1_q;
	logic sel_armed_q;
	logic sel_rise;
	logic pulse_seen_q;
	logic pulse_seen_d;
	rmc_hold_timer u_ce_timer
	(
		.core_clk_i(core_clk_i),
		.srst_i(srst_i),
		.level_i(act_s),
		.limit_i(rmc_pkg::CNT_W'(rmc_pkg::CE_MIN_CYC)),
		.done_o(ce_long)
	);
	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			sel_n_d1_q <= 1'b1;
			sel_armed_q <= 1'b0;
		end
		else
		begin
			sel_n_d1_q <= sel_n_s;
			sel_armed_q <= sel_armed_q || sel_n_s;
		end
	end
	assign sel_rise = sel_n_s && !sel_n_d1_q && sel_armed_q;

	// ----------------------------------------
	// mode state machine
	// ----------------------------------------
	rmc_pkg::rmc_mode_e state_q;
	rmc_pkg::rmc_mode_e state_d;
	rmc_pkg::rmc_mode_e target_q;
	rmc_pkg::rmc_mode_e target_d;
	logic [rmc_pkg::CNT_W-1:0] settle_q;
	logic settle_done;
	logic tx_req;
	logic rx_req;

	assign settle_done = settle_q == rmc_pkg::CNT_W'(rmc_pkg::STBY2ACT_CYC - 1);
	assign rx_req = power_on_bit_i && listen_role_bit_i && act_s;
	assign tx_req = power_on_bit_i && !listen_role_bit_i && !tx_fifo_empty_i;

	always_comb
	begin
		state_d = state_q;
		target_d = target_q;
		pulse_seen_d = pulse_seen_q;
		if (ce_long && state_q == rmc_pkg::ST_STBY1)
			pulse_seen_d = 1'b1;
		case (state_q)
			rmc_pkg::ST_POR:
			begin
				state_d = rmc_pkg::ST_PDOWN;
			end
			rmc_pkg::ST_PDOWN:
			begin
				if (power_on_bit_i)
					state_d = rmc_pkg::ST_STBY1;
			end
			rmc_pkg::ST_STBY1:
			begin
				if (rx_req)
				begin
					state_d = rmc_pkg::ST_SETTLE;
					target_d = rmc_pkg::ST_RX;
				end
				else if (tx_req && (pulse_seen_q || ce_long))
				begin
					state_d = rmc_pkg::ST_SETTLE;
					target_d = rmc_pkg::ST_TX;
				end
				else if (!listen_role_bit_i && act_s && tx_fifo_empty_i)
					state_d = rmc_pkg::ST_STBY2;
			end
			rmc_pkg::ST_STBY2:
			begin
				if (!act_s)
					state_d = rmc_pkg::ST_STBY1;
				else if (tx_req && sel_rise)
				begin
					state_d = rmc_pkg::ST_SETTLE;
					target_d = rmc_pkg::ST_TX;
				end
			end
			rmc_pkg::ST_SETTLE:
			begin
				if (settle_done)
					state_d = target_q;
			end
			rmc_pkg::ST_RX:
			begin
				// leave on standby, off, or listen role cleared for transmit
				if (!act_s)
					state_d = rmc_pkg::ST_STBY1;
				else if (!listen_role_bit_i)
				begin
					state_d = rmc_pkg::ST_SETTLE;
					target_d = rmc_pkg::ST_TX;
				end
			end
			rmc_pkg::ST_TX:
			begin
				if (packet_done_i)
				begin
					pulse_seen_d = 1'b0;
					if (!act_s)
						state_d = rmc_pkg::ST_STBY1;
					else if (listen_role_bit_i)
					begin
						state_d = rmc_pkg::ST_SETTLE;
						target_d = rmc_pkg::ST_RX;
					end
					else if (tx_fifo_empty_i)
						state_d = rmc_pkg::ST_STBY2;
				end
			end
			default:
			begin
				state_d = rmc_pkg::ST_PDOWN;
			end
		endcase
		// power bit low forces power down
		if (!power_on_bit_i && state_q != rmc_pkg::ST_POR)
		begin
			state_d = rmc_pkg::ST_PDOWN;
			pulse_seen_d = 1'b0;
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			state_q <= rmc_pkg::ST_POR;
			target_q <= rmc_pkg::ST_STBY1;
			pulse_seen_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			target_q <= target_d;
			pulse_seen_q <= pulse_seen_d;
		end
	end

	// settle counter on the core clock
	always_ff @(posedge core_clk_i)
	begin
		if (srst_i || state_q != rmc_pkg::ST_SETTLE)
			settle_q <= '0;
		else if (!settle_done)
			settle_q <= settle_q + 16'h0001;
	end

	assign mode_o = state_q;

	// ----------------------------------------
	// transmit fifo pop and receive storage
	// ----------------------------------------
	logic tx_pop_q;
	logic rx_store_q;
	logic rx_drop_q;
	logic rx_good;

	assign rx_good = rx_pkt_i.valid && rx_pkt_i.addr_match && rx_pkt_i.crc_ok;

	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			tx_pop_q <= 1'b0;
			rx_store_q <= 1'b0;
			rx_drop_q <= 1'b0;
		end
		else
		begin
			tx_pop_q <= state_q == rmc_pkg::ST_TX && packet_done_i;
			rx_store_q <= state_q == rmc_pkg::ST_RX && rx_good && !rx_fifo_full_i;
			rx_drop_q <= state_q == rmc_pkg::ST_RX && rx_good && rx_fifo_full_i;
		end
	end

	assign tx_pop_o = tx_pop_q;
	assign rx_store_o = rx_store_q;
	assign rx_drop_o = rx_drop_q;

	// ----------------------------------------
	// carrier sense filter
	// ----------------------------------------
	logic cs_done;
	logic cs_q;
	// signal held 128 us in receive
	rmc_hold_timer u_cs_timer
	(
		.core_clk_i(core_clk_i),
		.srst_i(srst_i),
		.level_i(rx_sig_s && state_q == rmc_pkg::ST_RX),
		.limit_i(rmc_pkg::CNT_W'(rmc_pkg::CS_HOLD_CYC)),
		.done_o(cs_done)
	);
	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
			cs_q <= 1'b0;
		else
			cs_q <= cs_done;
	end

	assign carrier_sense_o = cs_q;

	// ----------------------------------------
	// radio settings
	// ----------------------------------------
	rmc_pkg::rmc_radio_s radio_q;
	logic [11:0] freq_q;

	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			radio_q <= '{1'b1, rmc_pkg::PWR_RST, 1'b1, rmc_pkg::CH_RST};
			freq_q <= 12'(rmc_pkg::BASE_FREQ_MHZ) + {5'h00, rmc_pkg::CH_RST};
		end
		else
		begin
			radio_q.air_rate_select <= air_rate_select_i;
			radio_q.output_power_level <= output_power_level_i;
			radio_q.low_noise_gain_bit <= low_noise_gain_bit_i;
			radio_q.channel_number <= channel_number_i;
			freq_q <= 12'(rmc_pkg::BASE_FREQ_MHZ) + {5'h00, channel_number_i};
		end
	end

	assign radio_o = radio_q;
	assign freq_mhz_o = freq_q;
endmodule : rmc_mode_ctrl

// file: test/rmc_mode_ctrl_chk.sv
// checker bound to the radio mode control
`timescale 1ns/1ps
module rmc_mode_ctrl_chk
(
	input wire logic core_clk_i,
	input wire logic srst_i,
	input wire logic power_on_bit_i,
	input wire logic listen_role_bit_i,
	input wire logic [6:0] channel_number_i,
	input wire logic packet_done_i,
	input wire rmc_pkg::rmc_rxpkt_s rx_pkt_i,
	input wire logic rx_fifo_full_i,
	input wire rmc_pkg::rmc_mode_e mode_o,
	input wire logic carrier_sense_o,
	input wire logic rx_store_o,
	input wire logic rx_drop_o,
	input wire logic tx_pop_o,
	input wire logic [11:0] freq_mhz_o
);
	localparam int SETTLE_MAX = 13000;
	localparam int CS_MIN = 12800;
	int settle_cnt;
	int rx_cnt;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (srst_i);
	always_ff @(posedge core_clk_i)
		settle_cnt <= (srst_i || mode_o != rmc_pkg::ST_SETTLE) ? 0 : settle_cnt + 1;
	always_ff @(posedge core_clk_i)
		rx_cnt <= (srst_i || mode_o != rmc_pkg::ST_RX) ? 0 : rx_cnt + 1;
	sequence s_good;
		mode_o == rmc_pkg::ST_RX && rx_pkt_i.valid && rx_pkt_i.addr_match && rx_pkt_i.crc_ok;
	endsequence
	AST_WAKE: assert property (mode_o == rmc_pkg::ST_PDOWN && power_on_bit_i |=>
		mode_o == rmc_pkg::ST_STBY1) else $error("no standby after power on");
	AST_OFF: assert property (!power_on_bit_i && mode_o != rmc_pkg::ST_POR |=>
		mode_o == rmc_pkg::ST_PDOWN) else $error("no power down");
	AST_RXGATE: assert property (mode_o == rmc_pkg::ST_RX && $past(mode_o) != rmc_pkg::ST_RX
		|-> $past(power_on_bit_i) && $past(listen_role_bit_i)) else $error("bad receive entry");
	AST_SETTLE: assert property (mode_o == rmc_pkg::ST_SETTLE |-> settle_cnt < SETTLE_MAX)
		else $error("settle too long");
	AST_CS_RISE: assert property ($rose(carrier_sense_o) |->
		mode_o == rmc_pkg::ST_RX && rx_cnt >= CS_MIN) else $error("carrier sense early");
	AST_CS_LOW: assert property ((mode_o != rmc_pkg::ST_RX) [*2] |-> !carrier_sense_o)
		else $error("carrier sense outside receive");
	AST_STORE: assert property (s_good ##0 !rx_fifo_full_i |=> rx_store_o)
		else $error("packet not stored");
	AST_DROP: assert property (s_good ##0 rx_fifo_full_i |=> rx_drop_o && !rx_store_o)
		else $error("packet not dropped");
	AST_POP: assert property (mode_o == rmc_pkg::ST_TX && packet_done_i |=> tx_pop_o)
		else $error("no pop after packet");
	AST_FREQ: assert property (!$past(srst_i) |->
		freq_mhz_o == 12'h0960 + $past(channel_number_i)) else $error("bad frequency");
endmodule : rmc_mode_ctrl_chk
bind rmc_mode_ctrl rmc_mode_ctrl_chk i_chk (.core_clk_i, .srst_i, .power_on_bit_i,
	.listen_role_bit_i, .channel_number_i, .packet_done_i, .rx_pkt_i, .rx_fifo_full_i,
	.mode_o, .carrier_sense_o, .rx_store_o, .rx_drop_o, .tx_pop_o, .freq_mhz_o);

// file: test/rmc_host_model.sv
// host model driving the activate and select pins
`timescale 1ns/1ps
module rmc_host_model
(
	output logic activate_o,
	output logic select_n_o
);
	logic lnk_clk;
	initial
	begin
		lnk_clk = 1'b0;
		activate_o = 1'b0;
		select_n_o = 1'b1;
		forever #40 lnk_clk = ~lnk_clk;
	end
	task automatic wake();
		repeat (1875) @(posedge lnk_clk);
	endtask : wake
	task automatic set_act(input logic v);
		@(posedge lnk_clk);
		activate_o <= v;
	endtask : set_act
	task automatic pulse();
		set_act(1'b1);
		repeat (130) @(posedge lnk_clk);
		activate_o <= 1'b0;
	endtask : pulse
	task automatic upload();
		repeat (50) @(posedge lnk_clk);
		select_n_o <= 1'b0;
		repeat (8) @(posedge lnk_clk);
		select_n_o <= 1'b1;
	endtask : upload
endmodule : rmc_host_model

// file: test/tb_rmc_mode_ctrl.sv
// self-checking bench of the radio mode control
`timescale 1ns/1ps
module tb_rmc_mode_ctrl;
	logic core_clk_i, srst_i, power_on_bit_i, listen_role_bit_i, air_rate_select_i;
	logic low_noise_gain_bit_i, activate_pin_i, select_n_pin_i, tx_fifo_empty_i;
	logic packet_done_i, rx_signal_i, rx_fifo_full_i;
	logic carrier_sense_o, rx_store_o, rx_drop_o, tx_pop_o;
	logic [6:0] channel_number_i;
	logic [1:0] output_power_level_i;
	logic [11:0] freq_mhz_o;
	rmc_pkg::rmc_rxpkt_s rx_pkt_i;
	rmc_pkg::rmc_mode_e mode_o;
	rmc_pkg::rmc_radio_s radio_o;
	int fails, n_checks;
	rmc_mode_ctrl i_dut (.core_clk_i, .srst_i, .power_on_bit_i, .listen_role_bit_i,
		.air_rate_select_i, .channel_number_i, .output_power_level_i, .low_noise_gain_bit_i,
		.activate_pin_i, .select_n_pin_i, .tx_fifo_empty_i, .packet_done_i, .rx_signal_i,
		.rx_pkt_i, .rx_fifo_full_i, .mode_o, .carrier_sense_o, .rx_store_o, .rx_drop_o,
		.tx_pop_o, .radio_o, .freq_mhz_o);
	rmc_host_model i_host (.activate_o(activate_pin_i), .select_n_o(select_n_pin_i));
	initial
	begin
		core_clk_i = 1'b0;
		forever #5 core_clk_i = ~core_clk_i;
	end
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic conclude();
		if (fails == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : conclude
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wait_mode(input rmc_pkg::rmc_mode_e m, input int lim);
		for (int i = 0; i < lim && mode_o !== m; i++)
			@(negedge core_clk_i);
		chk(12'(mode_o), 12'(m));
		if (mode_o !== m)
			conclude();
	endtask : wait_mode
	task automatic watch(output logic [2:0] seen);
		seen = 3'h0;
		repeat (3)
		begin
			@(negedge core_clk_i);
			seen = seen | {rx_store_o, rx_drop_o, tx_pop_o};
		end
	endtask : watch
	task automatic t_pkt(input logic [2:0] p, input logic f);
		logic [2:0] seen;
		@(posedge core_clk_i);
		rx_pkt_i <= p;
		rx_fifo_full_i <= f;
		@(posedge core_clk_i);
		rx_pkt_i <= 3'h0;
		watch(seen);
		chk(12'(seen), 12'({p == 3'h7 && !f, p == 3'h7 && f, 1'b0}));
	endtask : t_pkt
	task automatic t_done(input logic e);
		logic [2:0] seen;
		@(posedge core_clk_i);
		packet_done_i <= 1'b1;
		tx_fifo_empty_i <= e;
		@(posedge core_clk_i);
		packet_done_i <= 1'b0;
		watch(seen);
		chk(12'(seen), 12'h001);
	endtask : t_done
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_cfg();
		wait_mode(rmc_pkg::ST_PDOWN, 4);
		power_on_bit_i <= 1'b1;
		wait_mode(rmc_pkg::ST_STBY1, 4);
		i_host.wake();
		for (int k = 0; k < 4; k++)
		begin
			@(posedge core_clk_i);
			output_power_level_i <= 2'(k);
			air_rate_select_i <= k[0];
			low_noise_gain_bit_i <= k[1];
			channel_number_i <= 7'(125 - k);
			repeat (2) @(negedge core_clk_i);
			chk(12'(radio_o), 12'({k[0], 2'(k), k[1], 7'(125 - k)}));
			chk(freq_mhz_o, 12'(2525 - k));
		end
		chk(12'(mode_o), 12'(rmc_pkg::ST_STBY1));
	endtask : t_cfg
	task automatic t_rx();
		listen_role_bit_i <= 1'b1;
		i_host.set_act(1'b1);
		wait_mode(rmc_pkg::ST_RX, 13100);
		t_pkt(3'h7, 1'b0);
		t_pkt(3'h6, 1'b0);
		t_pkt(3'h7, 1'b1);
		rx_signal_i <= 1'b1;
		repeat (12700) @(negedge core_clk_i);
		chk(12'(carrier_sense_o), 12'h000);
		for (int i = 0; i < 200 && carrier_sense_o !== 1'b1; i++)
			@(negedge core_clk_i);
		chk(12'(carrier_sense_o), 12'h001);
		rx_signal_i <= 1'b0;
		chk(12'(mode_o), 12'(rmc_pkg::ST_RX));
		i_host.set_act(1'b0);
		wait_mode(rmc_pkg::ST_STBY1, 8);
	endtask : t_rx
	task automatic t_tx();
		listen_role_bit_i <= 1'b0;
		tx_fifo_empty_i <= 1'b0;
		repeat (8) @(negedge core_clk_i);
		chk(12'(mode_o), 12'(rmc_pkg::ST_STBY1));
		i_host.pulse();
		wait_mode(rmc_pkg::ST_TX, 13200);
		t_done(1'b0);
		wait_mode(rmc_pkg::ST_STBY1, 8);
		i_host.set_act(1'b1);
		wait_mode(rmc_pkg::ST_TX, 14300);
		t_done(1'b1);
		wait_mode(rmc_pkg::ST_STBY2, 8);
		tx_fifo_empty_i <= 1'b0;
		i_host.upload();
		wait_mode(rmc_pkg::ST_TX, 13100);
	endtask : t_tx
	task automatic t_off();
		power_on_bit_i <= 1'b0;
		wait_mode(rmc_pkg::ST_PDOWN, 4);
		chk(freq_mhz_o, 12'h09da);
	endtask : t_off
	initial
	begin
		{srst_i, power_on_bit_i, listen_role_bit_i, air_rate_select_i} = 4'h8;
		{low_noise_gain_bit_i, tx_fifo_empty_i, packet_done_i, rx_signal_i} = 4'h4;
		{rx_fifo_full_i, rx_pkt_i, output_power_level_i} = 6'h00;
		channel_number_i = 7'h10;
		fails = 0;
		n_checks = 0;
		repeat (16) @(negedge core_clk_i);
		chk(12'(radio_o), 12'({1'b1, 2'h3, 1'b1, 7'h02}));
		@(posedge core_clk_i);
		srst_i <= 1'b0;
		t_cfg();
		t_rx();
		t_tx();
		t_off();
		conclude();
	end
endmodule : tb_rmc_mode_ctrl
